// [ilm_controller.sv]
`timescale 1ns/1ps
module ilm_controller (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire ilm_pkg::ilm_bus_req_s bus_req_in,
  input wire logic [63:0] pending_bits_in,
  input wire logic [63:0] forced_request_bits_in,
  output ilm_pkg::ilm_bus_rsp_s bus_rsp_out,
  output logic fiq_req_out,
  output logic irq_req_out,
  output logic [15:0] active_level_out,
  output logic [63:0] source_mask_bits_out
);

  localparam int N = ilm_pkg::SRC_NUM;
  localparam int LW = ilm_pkg::LVL_W;
  localparam int MW = ilm_pkg::MASK_W;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [ilm_pkg::CFG_W-1:0] cfg_q;
  logic [ilm_pkg::CFG_W-1:0] cfg_d;
  logic [MW-1:0] cur_mask_q;
  logic [MW-1:0] cur_mask_d;
  logic [MW-1:0] sav_mask_q;
  logic [MW-1:0] sav_mask_d;
  logic [N-1:0] src_mask_q;
  logic [N-1:0] src_mask_d;
  ilm_pkg::ilm_bus_rsp_s rsp_q;
  ilm_pkg::ilm_bus_rsp_s rsp_d;
  logic fiq_q;
  logic fiq_d;
  logic irq_q;
  logic irq_d;
  logic [ilm_pkg::LVL_NUM-1:0] act_lvl_q;
  logic [ilm_pkg::LVL_NUM-1:0] act_lvl_d;

  logic [N*LW-1:0] levels;
  logic [LW-1:0] lvl [N];
  logic [N-1:0] active;
  logic [N-1:0] is_fast;
  logic auto_mask;
  logic [4:0] fast_def;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic req_rd;
  logic req_wr;
  logic aligned;
  logic sel_pend_hi;
  logic sel_pend_lo;
  logic sel_mask_hi;
  logic sel_mask_lo;
  logic sel_force_hi;
  logic sel_force_lo;
  logic sel_cfg;
  logic sel_ports;
  logic sel_lvl;
  logic sel_ack_n;
  logic sel_ack_f;
  logic mapped;
  logic bad_write;
  logic [3:0] lvl_word;

  always_comb begin
    req_rd = bus_req_in.valid && !bus_req_in.write;
    req_wr = bus_req_in.valid && bus_req_in.write;
    aligned = (bus_req_in.addr[1:0] == 2'b00);
    sel_pend_hi = aligned && (bus_req_in.addr == ilm_pkg::OFF_PEND_HI);
    sel_pend_lo = aligned && (bus_req_in.addr == ilm_pkg::OFF_PEND_LO);
    sel_mask_hi = aligned && (bus_req_in.addr == ilm_pkg::OFF_MASK_HI);
    sel_mask_lo = aligned && (bus_req_in.addr == ilm_pkg::OFF_MASK_LO);
    sel_force_hi = aligned && (bus_req_in.addr == ilm_pkg::OFF_FORCE_HI);
    sel_force_lo = aligned && (bus_req_in.addr == ilm_pkg::OFF_FORCE_LO);
    sel_cfg = aligned && (bus_req_in.addr == ilm_pkg::OFF_CONFIG);
    sel_ports = aligned && (bus_req_in.addr == ilm_pkg::OFF_PORTS);
    sel_lvl = aligned && (bus_req_in.addr >= ilm_pkg::OFF_LVL_FIRST) &&
              (bus_req_in.addr <= ilm_pkg::OFF_LVL_LAST);
    sel_ack_n = aligned && (bus_req_in.addr == ilm_pkg::OFF_ACK_NORMAL);
    sel_ack_f = aligned && (bus_req_in.addr == ilm_pkg::OFF_ACK_FAST);
    mapped = sel_pend_hi || sel_pend_lo || sel_mask_hi || sel_mask_lo ||
             sel_force_hi || sel_force_lo || sel_cfg || sel_ports ||
             sel_lvl || sel_ack_n || sel_ack_f;
    // Pending and acknowledge words are read-only
    bad_write = sel_ack_n || sel_ack_f || sel_pend_hi || sel_pend_lo;
    lvl_word = bus_req_in.addr[5:2];
  end

  // ----------------------------------------------------------------
  // Source level table
  // ----------------------------------------------------------------
  ilm_level_table #(
    .N(N),
    .W(LW)
  ) u_levels (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(req_wr && sel_lvl),
    .word_in(lvl_word),
    .be_in(bus_req_in.be),
    .wdata_in(bus_req_in.wdata),
    .levels_out(levels)
  );

  assign auto_mask = cfg_q[ilm_pkg::CFG_AUTO_MASK_BIT];
  assign fast_def = cfg_q[4:0];

  // ----------------------------------------------------------------
  // Recognition and class per source
  // ----------------------------------------------------------------
  for (genvar s = 0; s < N; s++) begin : g_src
    logic requested;
    logic above_mask;

    assign lvl[s] = levels[s * LW +: LW];
    assign requested = (pending_bits_in[s] && !src_mask_q[s]) ||
                       forced_request_bits_in[s];
    // Mask 0x1F is -1 and passes all; other negative codes and 15 block all
    assign above_mask = (cur_mask_q == ilm_pkg::LMASK_PASS_ALL) ||
                        (!cur_mask_q[4] && (lvl[s] > cur_mask_q[3:0]));
    assign active[s] = requested && above_mask;
    // Zero routes everything fast; v routes levels v-1 and up
    assign is_fast[s] = (fast_def == 5'h00) ||
                        ({1'b0, lvl[s]} >= (fast_def - 5'h01));
  end

  // ----------------------------------------------------------------
  // Prioritisation
  // ----------------------------------------------------------------
  logic found_f;
  logic found_n;
  logic [LW-1:0] best_lvl_f;
  logic [LW-1:0] best_lvl_n;
  logic [ilm_pkg::IDX_W-1:0] best_idx_f;
  logic [ilm_pkg::IDX_W-1:0] best_idx_n;

  // Ascending scan with >= lets the higher index win a tied level
  always_comb begin
    found_f = 1'b0;
    found_n = 1'b0;
    best_lvl_f = '0;
    best_lvl_n = '0;
    best_idx_f = '0;
    best_idx_n = '0;
    for (int i = 0; i < N; i++) begin
      if (active[i] && is_fast[i] && (!found_f || (lvl[i] >= best_lvl_f))) begin
        found_f = 1'b1;
        best_lvl_f = lvl[i];
        best_idx_f = ilm_pkg::IDX_W'(i);
      end
      if (active[i] && !is_fast[i] && (!found_n || (lvl[i] >= best_lvl_n))) begin
        found_n = 1'b1;
        best_lvl_n = lvl[i];
        best_idx_n = ilm_pkg::IDX_W'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Processor requests and decoded levels
  // ----------------------------------------------------------------
  always_comb begin
    act_lvl_d = '0;
    for (int i = 0; i < N; i++) begin
      if (active[i]) begin
        act_lvl_d[lvl[i]] = 1'b1;
      end
    end
    fiq_d = |(active & is_fast);
    irq_d = |(active & ~is_fast);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fiq_q <= 1'b0;
      irq_q <= 1'b0;
      act_lvl_q <= '0;
    end else begin
      fiq_q <= fiq_d;
      irq_q <= irq_d;
      act_lvl_q <= act_lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge
  // ----------------------------------------------------------------
  logic ack_take;
  logic ack_found;
  logic [LW-1:0] ack_lvl;
  logic [ilm_pkg::IDX_W-1:0] ack_idx;
  logic [ilm_pkg::VEC_W-1:0] ack_vec;

  always_comb begin
    ack_take = req_rd && (sel_ack_n || sel_ack_f);
    ack_found = sel_ack_f ? found_f : found_n;
    ack_lvl = sel_ack_f ? best_lvl_f : best_lvl_n;
    ack_idx = sel_ack_f ? best_idx_f : best_idx_n;
    if (ack_found) begin
      ack_vec = ilm_pkg::VEC_BASE + {2'b00, ack_idx};
    end else begin
      ack_vec = ilm_pkg::VEC_SPURIOUS;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and level masks
  // ----------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    cur_mask_d = cur_mask_q;
    sav_mask_d = sav_mask_q;
    if (req_wr && sel_cfg && bus_req_in.be[ilm_pkg::LANE_CONFIG]) begin
      cfg_d = bus_req_in.wdata[ilm_pkg::CFG_W-1:0];
    end
    if (req_wr && sel_ports && bus_req_in.be[ilm_pkg::LANE_CUR]) begin
      cur_mask_d = bus_req_in.wdata[ilm_pkg::LANE_CUR * 8 +: MW];
    end
    if (req_wr && sel_ports && bus_req_in.be[ilm_pkg::LANE_SAV]) begin
      sav_mask_d = bus_req_in.wdata[ilm_pkg::LANE_SAV * 8 +: MW];
    end
    // A spurious acknowledge has no level to load, so masks stay
    if (ack_take && ack_found && auto_mask) begin
      sav_mask_d = cur_mask_q;
      cur_mask_d = {1'b0, ack_lvl};
    end
    // With auto-mask clear the acknowledge path above never fires
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cfg_q <= ilm_pkg::CFG_RST;
      cur_mask_q <= ilm_pkg::LMASK_RST;
      sav_mask_q <= ilm_pkg::LMASK_RST;
    end else begin
      cfg_q <= cfg_d;
      cur_mask_q <= cur_mask_d;
      sav_mask_q <= sav_mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Per-source mask bits
  // ----------------------------------------------------------------
  logic [7:0] set_val;
  logic [7:0] clr_val;
  logic set_wr;
  logic clr_wr;

  always_comb begin
    set_val = bus_req_in.wdata[ilm_pkg::LANE_SET * 8 +: 8];
    clr_val = bus_req_in.wdata[ilm_pkg::LANE_CLR * 8 +: 8];
    set_wr = req_wr && sel_ports && bus_req_in.be[ilm_pkg::LANE_SET];
    clr_wr = req_wr && sel_ports && bus_req_in.be[ilm_pkg::LANE_CLR];
    src_mask_d = src_mask_q;
    for (int b = 0; b < 4; b++) begin
      if (req_wr && sel_mask_hi && bus_req_in.be[b]) begin
        src_mask_d[32 + b * 8 +: 8] = bus_req_in.wdata[b * 8 +: 8];
      end
      if (req_wr && sel_mask_lo && bus_req_in.be[b]) begin
        src_mask_d[b * 8 +: 8] = bus_req_in.wdata[b * 8 +: 8];
      end
    end
    // Clear first, then set, so a set in the same access wins
    if (clr_wr) begin
      if (clr_val[ilm_pkg::PORT_GLOBAL_BIT]) begin
        src_mask_d = '0;
      end else begin
        src_mask_d[clr_val[5:0]] = 1'b0;
      end
    end
    if (set_wr) begin
      if (set_val[ilm_pkg::PORT_GLOBAL_BIT]) begin
        src_mask_d = '1;
      end else begin
        src_mask_d[set_val[5:0]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      src_mask_q <= ilm_pkg::SRC_MASK_RST;
    end else begin
      src_mask_q <= src_mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  logic [31:0] lvl_rdata;

  always_comb begin
    lvl_rdata = '0;
    for (int k = 0; k < 4; k++) begin
      lvl_rdata[k * 8 +: LW] = lvl[{lvl_word, 2'(k)}];
    end
  end

  always_comb begin
    rsp_d.ack = bus_req_in.valid;
    rsp_d.err = bus_req_in.valid && (!mapped || (bus_req_in.write && bad_write));
    rsp_d.rdata = '0;
    if (req_rd && mapped) begin
      unique case (1'b1)
        sel_pend_hi: rsp_d.rdata = pending_bits_in[63:32];
        sel_pend_lo: rsp_d.rdata = pending_bits_in[31:0];
        sel_mask_hi: rsp_d.rdata = src_mask_q[63:32];
        sel_mask_lo: rsp_d.rdata = src_mask_q[31:0];
        sel_force_hi: rsp_d.rdata = forced_request_bits_in[63:32];
        sel_force_lo: rsp_d.rdata = forced_request_bits_in[31:0];
        sel_cfg: rsp_d.rdata = {26'h000_0000, cfg_q};
        // Set and clear lanes always read back zero
        sel_ports: rsp_d.rdata = {3'b000, sav_mask_q, 3'b000, cur_mask_q, 16'h0000};
        sel_lvl: rsp_d.rdata = lvl_rdata;
        sel_ack_n: rsp_d.rdata = {24'h00_0000, ack_vec};
        sel_ack_f: rsp_d.rdata = {24'h00_0000, ack_vec};
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // Software must program levels before unmasking any source
  // Nested handlers restore the saved mask themselves
  assign bus_rsp_out = rsp_q;
  assign fiq_req_out = fiq_q;
  assign irq_req_out = irq_q;
  assign active_level_out = act_lvl_q;
  assign source_mask_bits_out = src_mask_q;

endmodule

// [ilm_pkg.sv]
package ilm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int SRC_NUM = 64;
  localparam int LVL_W = 4;
  localparam int LVL_NUM = 16;
  localparam int MASK_W = 5;
  localparam int VEC_W = 8;
  localparam int IDX_W = 6;

  // ----------------------------------------------------------------
  // Byte offsets of the words
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PEND_HI = 8'h00;
  localparam logic [7:0] OFF_PEND_LO = 8'h04;
  localparam logic [7:0] OFF_MASK_HI = 8'h08;
  localparam logic [7:0] OFF_MASK_LO = 8'h0C;
  localparam logic [7:0] OFF_FORCE_HI = 8'h10;
  localparam logic [7:0] OFF_FORCE_LO = 8'h14;
  localparam logic [7:0] OFF_CONFIG = 8'h18;
  localparam logic [7:0] OFF_PORTS = 8'h1C;
  localparam logic [7:0] OFF_LVL_FIRST = 8'h40;
  localparam logic [7:0] OFF_LVL_LAST = 8'h7C;
  localparam logic [7:0] OFF_ACK_NORMAL = 8'hEC;
  localparam logic [7:0] OFF_ACK_FAST = 8'hF0;

  // ----------------------------------------------------------------
  // Byte lanes and fields
  // ----------------------------------------------------------------
  localparam int LANE_CONFIG = 0;
  localparam int LANE_SET = 0;
  localparam int LANE_CLR = 1;
  localparam int LANE_CUR = 2;
  localparam int LANE_SAV = 3;
  localparam int CFG_AUTO_MASK_BIT = 5;
  localparam int CFG_W = 6;
  localparam int PORT_GLOBAL_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
  localparam logic [MASK_W-1:0] LMASK_RST = 5'h1F;
  localparam logic [MASK_W-1:0] LMASK_PASS_ALL = 5'h1F;
  localparam logic [SRC_NUM-1:0] SRC_MASK_RST = {SRC_NUM{1'b1}};
  localparam logic [LVL_W-1:0] LVL_RST = 4'h0;
  localparam logic [VEC_W-1:0] VEC_SPURIOUS = 8'h3F;
  localparam logic [VEC_W-1:0] VEC_BASE = 8'h40;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ilm_bus_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } ilm_bus_rsp_s;

endpackage

// [ilm_level_table.sv]
`timescale 1ns/1ps
module ilm_level_table #(
  parameter int N = 64,
  parameter int W = 4
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic [3:0] word_in,
  input wire logic [3:0] be_in,
  input wire logic [31:0] wdata_in,
  output logic [N*W-1:0] levels_out
);

  logic [W-1:0] lvl_q [N];
  logic [W-1:0] lvl_d [N];

  // ----------------------------------------------------------------
  // One entry per source, four entries to a bus word
  // ----------------------------------------------------------------
  for (genvar e = 0; e < N; e++) begin : g_entry
    always_comb begin
      lvl_d[e] = lvl_q[e];
      if (wr_en_in && (word_in == 4'(e / 4)) && be_in[e % 4]) begin
        lvl_d[e] = wdata_in[(e % 4) * 8 +: W];
      end
    end

    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        lvl_q[e] <= ilm_pkg::LVL_RST;
      end else begin
        lvl_q[e] <= lvl_d[e];
      end
    end

    assign levels_out[e * W +: W] = lvl_q[e];
  end

endmodule

// [ilm_monitor.sv]
`timescale 1ns/1ps
module ilm_monitor (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire ilm_pkg::ilm_bus_req_s bus_req_in,
  input wire logic [63:0] pending_bits_in,
  input wire logic [63:0] forced_request_bits_in,
  input wire ilm_pkg::ilm_bus_rsp_s bus_rsp_out,
  input wire logic fiq_req_out,
  input wire logic irq_req_out,
  input wire logic [15:0] active_level_out,
  input wire logic [63:0] source_mask_bits_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  logic pw;
  logic pr;
  logic aw;
  assign pw = bus_req_in.valid && bus_req_in.write && bus_req_in.addr == ilm_pkg::OFF_PORTS;
  assign pr = bus_req_in.valid && !bus_req_in.write && bus_req_in.addr == ilm_pkg::OFF_PORTS;
  assign aw = bus_req_in.valid && bus_req_in.write &&
    (bus_req_in.addr == ilm_pkg::OFF_ACK_NORMAL || bus_req_in.addr == ilm_pkg::OFF_ACK_FAST);

  set_one_a: assert property (
    pw && bus_req_in.be[0] && !bus_req_in.be[1] && !bus_req_in.wdata[6] |=>
    source_mask_bits_out == ($past(source_mask_bits_out) | (64'h1 << $past(bus_req_in.wdata[5:0]))))
    else $error("single mask set wrong");
  set_wins_a: assert property (
    pw && bus_req_in.be[0] && bus_req_in.be[1] && !bus_req_in.wdata[6] |=>
    source_mask_bits_out[$past(bus_req_in.wdata[5:0])])
    else $error("set lost against clear");
  set_all_a: assert property (
    pw && bus_req_in.be[0] && bus_req_in.wdata[6] |=> &source_mask_bits_out)
    else $error("global mask set wrong");
  clr_one_a: assert property (
    pw && bus_req_in.be[1] && !bus_req_in.be[0] && !bus_req_in.wdata[14] |=>
    source_mask_bits_out == ($past(source_mask_bits_out) & ~(64'h1 << $past(bus_req_in.wdata[13:8]))))
    else $error("single mask clear wrong");
  clr_all_a: assert property (
    pw && bus_req_in.be[1] && !bus_req_in.be[0] && bus_req_in.wdata[14] |=>
    source_mask_bits_out == 64'h0)
    else $error("global mask clear wrong");
  ports_zero_a: assert property (
    pr |=> bus_rsp_out.ack && !bus_rsp_out.err && bus_rsp_out.rdata[15:0] == 16'h0)
    else $error("port lanes not read as zero");
  ack_wr_err_a: assert property (
    aw |=> bus_rsp_out.ack && bus_rsp_out.err && bus_rsp_out.rdata == 32'h0)
    else $error("acknowledge write not refused");
  quiet_none_a: assert property (
    (pending_bits_in & ~source_mask_bits_out) == 64'h0 && forced_request_bits_in == 64'h0 |=>
    active_level_out == 16'h0 && !fiq_req_out && !irq_req_out)
    else $error("request without active source");
  level_req_a: assert property (
    (active_level_out != 16'h0) == (fiq_req_out || irq_req_out))
    else $error("request lines disagree with levels");
endmodule

bind ilm_controller ilm_monitor ilm_monitor_i (
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .bus_req_in(bus_req_in),
  .pending_bits_in(pending_bits_in),
  .forced_request_bits_in(forced_request_bits_in),
  .bus_rsp_out(bus_rsp_out),
  .fiq_req_out(fiq_req_out),
  .irq_req_out(irq_req_out),
  .active_level_out(active_level_out),
  .source_mask_bits_out(source_mask_bits_out)
);

// [ilm_core_model.sv]
`timescale 1ns/1ps
module ilm_core_model (
  input wire logic clk_in,
  input wire ilm_pkg::ilm_bus_rsp_s bus_rsp_in,
  output ilm_pkg::ilm_bus_req_s bus_req_out
);
  initial bus_req_out = '0;

  // Released fields carry inverted values so a design that samples them late is caught
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd, output logic e);
    @(posedge clk_in);
    bus_req_out <= '{valid: 1'b1, write: w, addr: a, be: be, wdata: wd};
    @(posedge clk_in);
    bus_req_out <= '{valid: 1'b0, write: ~w, addr: ~a, be: ~be, wdata: ~wd};
    // The answer is taken at the edge where its acknowledge is sampled high
    @(posedge clk_in);
    rd = bus_rsp_in.rdata;
    e = bus_rsp_in.ack ? bus_rsp_in.err : 1'bx;
  endtask
endmodule

// [tb_ilm_controller.sv]
`timescale 1ns/1ps
module tb_ilm_controller;
  logic clk_in;
  logic sys_rst_in;
  logic [63:0] pend;
  logic [63:0] frc;
  ilm_pkg::ilm_bus_req_s req;
  ilm_pkg::ilm_bus_rsp_s rsp;
  logic fiq;
  logic irq;
  logic [15:0] act;
  logic [63:0] msk;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic e;
  logic [4:0] cur_tab [6] = '{5'h02, 5'h03, 5'h0E, 5'h0F, 5'h1E, 5'h1F};
  logic [15:0] act_tab [6] = '{16'h8008, 16'h8000, 16'h8000, 16'h0000, 16'h0000, 16'h8008};

  ilm_controller ilm_controller_i (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .bus_req_in(req),
    .pending_bits_in(pend),
    .forced_request_bits_in(frc),
    .bus_rsp_out(rsp),
    .fiq_req_out(fiq),
    .irq_req_out(irq),
    .active_level_out(act),
    .source_mask_bits_out(msk)
  );

  ilm_core_model ilm_core_model_i (
    .clk_in(clk_in),
    .bus_rsp_in(rsp),
    .bus_req_out(req)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Whole run needs about 130 cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ilm_core_model_i.xfer(1'b0, a, 4'hF, 32'h0, rd, e);
    chk("read err", {63'h0, e}, 64'h0);
    chk("read data", {32'h0, rd}, {32'h0, exp});
  endtask

  task automatic wrc(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                     input logic ee);
    ilm_core_model_i.xfer(1'b1, a, be, d, rd, e);
    chk("write err", {63'h0, e}, {63'h0, ee});
  endtask

  task automatic settle;
    @(posedge clk_in);
    #1;
  endtask

  task automatic chk_req(input logic f, input logic i, input logic [15:0] lv);
    chk("fast req", {63'h0, fiq}, {63'h0, f});
    chk("normal req", {63'h0, irq}, {63'h0, i});
    chk("levels", {48'h0, act}, {48'h0, lv});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst_in = 1'b1;
    pend = 64'h0;
    frc = 64'h0;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rdc(8'h18, 32'h0000_0000);
    rdc(8'h1C, 32'h1F1F_0000);
    rdc(8'h7C, 32'h0000_0000);
    rdc(8'hEC, 32'h0000_003F);
    rdc(8'hF0, 32'h0000_003F);
    // Levels first, then unmask sources 5, 6 and 63
    wrc(8'h44, 4'h6, 32'h00F3_F300, 1'b0);
    rdc(8'h44, 32'h0003_0300);
    wrc(8'h7C, 4'h8, 32'h0F00_0000, 1'b0);
    wrc(8'h1C, 4'h2, 32'h0000_0500, 1'b0);
    wrc(8'h1C, 4'h2, 32'h0000_0600, 1'b0);
    wrc(8'h1C, 4'h2, 32'h0000_3F00, 1'b0);
    chk("mask", msk, ~64'h8000_0000_0000_0060);
    @(posedge clk_in);
    pend <= 64'h0000_0000_0000_0060;
    settle();
    chk_req(1'b1, 1'b0, 16'h0008);
    rdc(8'hEC, 32'h0000_003F);
    rdc(8'hF0, 32'h0000_0046);
    rdc(8'h1C, 32'h1F1F_0000);
    wrc(8'h18, 4'h1, 32'h0000_0005, 1'b0);
    settle();
    chk_req(1'b0, 1'b1, 16'h0008);
    rdc(8'hEC, 32'h0000_0046);
    rdc(8'hF0, 32'h0000_003F);
    wrc(8'h18, 4'h1, 32'h0000_0004, 1'b0);
    settle();
    chk_req(1'b1, 1'b0, 16'h0008);
    // Automatic masking on acknowledge
    @(posedge clk_in);
    pend <= 64'h8000_0000_0000_0060;
    wrc(8'h18, 4'h1, 32'h0000_0020, 1'b0);
    settle();
    chk_req(1'b1, 1'b0, 16'h8008);
    rdc(8'hF0, 32'h0000_007F);
    settle();
    chk_req(1'b0, 1'b0, 16'h0000);
    rdc(8'h1C, 32'h1F0F_0000);
    rdc(8'hF0, 32'h0000_003F);
    for (int k = 0; k < 6; k++) begin
      wrc(8'h1C, 4'h4, {11'h0, cur_tab[k], 16'h0}, 1'b0);
      settle();
      chk("levels", {48'h0, act}, {48'h0, act_tab[k]});
    end
    // Mask ports and forced requests
    wrc(8'h1C, 4'h1, 32'h0000_0040, 1'b0);
    chk("mask", msk, ~64'h0);
    settle();
    chk("levels", {48'h0, act}, 64'h0);
    @(posedge clk_in);
    frc <= 64'h0000_0000_0000_0040;
    settle();
    chk("levels", {48'h0, act}, 64'h0008);
    wrc(8'h1C, 4'h2, 32'h0000_4000, 1'b0);
    chk("mask", msk, 64'h0);
    wrc(8'h1C, 4'h3, 32'h0000_0909, 1'b0);
    chk("mask", msk, 64'h0000_0000_0000_0200);
    wrc(8'h1C, 4'h2, 32'h0000_0900, 1'b0);
    chk("mask", msk, 64'h0);
    wrc(8'h1C, 4'h1, 32'h0000_003F, 1'b0);
    chk("mask", msk, 64'h8000_0000_0000_0000);
    wrc(8'h1C, 4'h3, 32'h0000_4005, 1'b0);
    chk("mask", msk, 64'h0000_0000_0000_0020);
    wrc(8'hEC, 4'hF, 32'h0000_0055, 1'b1);
    wrc(8'hF0, 4'hF, 32'h0000_0055, 1'b1);
    ilm_core_model_i.xfer(1'b0, 8'h20, 4'hF, 32'h0, rd, e);
    chk("unmapped err", {63'h0, e}, 64'h1);
    report_and_stop();
  end
endmodule
